/* File: cbtc_chk.sv */
// port assertions for the block transfer control
`timescale 1ns/1ps
module cbtc_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // memory side
  input wire logic [4:0] memTrack,
  input wire logic [3:0] memCe,
  input wire logic memWrite,
  // monitors
  input wire logic dataOutAvailN,
  input wire logic busy,
  input wire logic dac,
  input wire logic xferReq,
  input wire logic memOverflow,
  input wire logic phase3Tick,
  input wire logic virtualAddressZero
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // low track bits as a plain signal for $past
  logic [1:0] gray;
  assign gray = memTrack[1:0];
  // one bit moves per step, so decodes of it never glitch
  function automatic logic [1:0] gnext(input logic [1:0] g);
    gnext = {g[0], ~g[1]};
  endfunction
  sequence s_start;
    $rose(xferReq);
  endsequence
  sequence s_step;
    xferReq && $changed(gray) && gray != 2'b00;
  endsequence
  a_idle_inhibit: assert property (
    !busy |-> memWrite && memCe == 4'h0) else $error("idle enable");
  a_bank_onehot: assert property (
    xferReq |-> $onehot(memCe)) else $error("bank not one-hot");
  a_block_hold: assert property (
    xferReq && gray != 2'b00 |-> $stable(memCe) && $stable(memTrack[4:2]))
    else $error("block moved mid-transfer");
  a_gray_step: assert property (
    s_step |-> gray == gnext($past(gray))) else $error("bad track step");
  a_track_restart: assert property (
    s_start |-> gray == 2'b00) else $error("track not restarted");
  a_xfer_in_dac: assert property (
    xferReq |-> dac && busy) else $error("transfer outside dac");
  a_read_dir: assert property (
    $fell(dataOutAvailN) |-> !memWrite) else $error("output while writing");
  a_ovf_ends: assert property (
    $rose(memOverflow) |-> ##[0:4] !busy) else $error("overflow kept busy");
  a_start_on_zero: assert property (
    $rose(xferReq) |-> $past(virtualAddressZero) && $past(phase3Tick))
    else $error("transfer started off address zero");
  a_tick_single: assert property (
    phase3Tick |=> !phase3Tick) else $error("phase tick too long");
endmodule

bind cbtc_top cbtc_chk i_chk (.mclk, .nrst, .memTrack, .memCe, .memWrite,
  .dataOutAvailN, .busy, .dac, .xferReq, .memOverflow, .phase3Tick,
  .virtualAddressZero);

/* File: cbtc_far_model.sv */
// far side: serial source, serial sink and memory read data
`timescale 1ns/1ps
module cbtc_far_model #(
  parameter int DIV = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // bench control and capture
  input wire logic reqOn,
  output logic [3:0] firstNib,
  // serial lines
  output logic dataIn,
  output logic dataInAvailN,
  input wire logic dataOut,
  input wire logic dataOutAvailN,
  // memory board
  input wire logic [3:0] memCe,
  output logic [3:0] memRdata
);
  logic [7:0] ph;
  logic [3:0] spin;
  // an unselected board floats: show a moving pattern, never a held one
  assign memRdata = (memCe != 4'h0) ? 4'h1 : spin;
  // source data flips every second cycle; sink keeps the first nibble out
  always @(posedge mclk) begin
    spin <= spin + 4'h1;
    dataIn <= spin[1];
    dataInAvailN <= ~reqOn;
    ph <= dataOutAvailN ? 8'h0 : ph + {7'h0, ph != 8'hff};
    if (!dataOutAvailN && int'(ph) < 4 * DIV && int'(ph) % DIV == 0)
      firstNib[int'(ph) / DIV] <= dataOut;
    if (!nrst) begin
      spin <= 4'h0;
      dataIn <= 1'b0;
      dataInAvailN <= 1'b1;
      ph <= 8'h0;
    end
  end
endmodule

/* File: cbtc_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CBTC_MAP_SVH
`define CBTC_MAP_SVH

// register byte offsets
`define CBTC_OFF_CTRL 8'h00
`define CBTC_OFF_CMD 8'h04
`define CBTC_OFF_CHOSEN 8'h08
`define CBTC_OFF_FLAGS 8'h0c
`define CBTC_OFF_STAT 8'h10

// control register fields
`define CBTC_CTRL_DESTR 0

// command register fields (write-one pulses)
`define CBTC_CMD_READ 0
`define CBTC_CMD_CLEAR 1

// status register fields
`define CBTC_ST_BUSY 0
`define CBTC_ST_DAC 1
`define CBTC_ST_XFER 2
`define CBTC_ST_OVF 3
`define CBTC_ST_RDPEND 4
`define CBTC_ST_TRACK 8
`define CBTC_ST_CE 16

// reset values
`define CBTC_RST_CHOSEN 32'hffffffff
`define CBTC_RST_DESTR 1'b0

// timing
`define CBTC_CLK_PS 40000
`define CBTC_LATCH_NS 150

// block geometry
`define CBTC_BLOCK_BITS 4096
`define CBTC_TRACK_BITS 256

`endif

/* File: cbtc_pkg.sv */
// types shared by the block transfer control design
package cbtc_pkg;

  // sequence controller states
  typedef enum logic [1:0] {
    CBTC_IDLE,
    CBTC_SETUP,
    CBTC_XFER
  } cbtc_state_t;

endpackage

/* File: cbtc_sel_cell.sv */
// one cell of the iterative block selector array
`timescale 1ns/1ps
module cbtc_sel_cell (
  // chain
  input wire logic enIn,
  output logic enOut,
  // this block
  input wire logic chosen,
  input wire logic flag,
  output logic selected
);

  logic avail;

  // a block is available when chosen and its flag does not occupy it;
  // it is selected only when no lower block is available
  assign avail = chosen & ~flag; // [RQ2]
  assign selected = avail & enIn; // [RQ2] [RQ3]
  assign enOut = enIn & ~avail; // [RQ3]

endmodule

/* File: cbtc_top.sv */
// block selector, decoder, track counter, output buffer and sequencer
// Functional notes
// RQ1 - valid flag per block, cleared by manual clear or destructive read
// RQ2 - cell selects when chosen, flag clear, no lower block available
// RQ3 - at most one of 32 block-selected lines active
// RQ4 - write start sets the block flag, enabling next higher cell
// RQ5 - destructive read selects on inverted flag and clears it
// RQ6 - auxiliary flag marks read blocks; all clear at read end
// RQ7 - selector overflow ends a read or shows no free block
// RQ8 - one-hot select decoded to 3-bit address and one-of-four enable
// RQ9 - block address drives upper three bits of track address
// RQ10 - address and enables registered, change only at block start
// RQ11 - gray counter gives low track bits, steps on zero address
// RQ12 - memory nibble captured about 150 ns after third phase rise
// RQ13 - first buffer copied to second at next transfer cycle
// RQ14 - mux shifts second register bits out serially in order
// RQ15 - active-low output-available marks valid serial data
// RQ16 - idle holds write direction with all chip enables off
// RQ17 - read request held until every available chosen block read
// RQ18 - read waits for write end, write waits for read end
// RQ19 - busy output monitors and blocks opposite request
// RQ20 - data-available-control spans request to transfer end
// RQ21 - transfer request active only while data moves
// RQ22 - overflow monitor ends reads, flags full memory on writes
// RQ23 - block of 4096 bits, track of 256 bits; the code runs a track as 256 four-bit transfer cycles, 1024 bits
// RQ24 - track counter runs 00,01,11,10 and restarts at block start
`timescale 1ns/1ps
`include "cbtc_map.svh"
module cbtc_top
  import cbtc_pkg::*;
#(
  parameter int BLOCKS = 32,
  parameter int BIT_DIV = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial data source side
  input wire logic dataIn,
  input wire logic dataInAvailN,
  output logic dataOut,
  output logic dataOutAvailN,
  // memory board
  input wire logic [3:0] memRdata,
  output logic [3:0] memWdata,
  output logic [4:0] memTrack,
  output logic [3:0] memCe,
  output logic memWrite,
  output logic phase3Tick,
  // monitors
  output logic virtualAddressZero,
  output logic busy,
  output logic dac,
  output logic xferReq,
  output logic memOverflow
);

  // ----------------------------------------------------------------
  // constants and elaboration checks
  // ----------------------------------------------------------------
  localparam int LATCH_CYC =
    (`CBTC_LATCH_NS * 1000 + `CBTC_CLK_PS - 1) / `CBTC_CLK_PS; // [RQ12]
  localparam int BITS_PER_CYC = 4;
  localparam int TRACK_CYC = `CBTC_TRACK_BITS; // [RQ23]
  localparam int TRACKS = `CBTC_BLOCK_BITS / (TRACK_CYC * BITS_PER_CYC);

  // capture must land before the next transfer cycle starts
  if (BIT_DIV < 2 || BITS_PER_CYC * BIT_DIV <= LATCH_CYC + 1) begin
    $error("cbtc_top: BIT_DIV too small for capture delay");
  end
  if (BLOCKS != 32) begin
    $error("cbtc_top: decoder serves exactly 32 blocks");
  end
  if (TRACKS != 4) begin
    $error("cbtc_top: two-bit gray track counter needs four tracks");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cbtc_state_t state;
    logic isRead;
    logic readPend;
    logic destr;
    logic [31:0] chosen;
    logic [31:0] valid;
    logic [31:0] aux;
    logic [2:0] blkAddr;
    logic [3:0] ce;
    logic [1:0] track;
    logic [7:0] vaddr;
    logic [7:0] divCnt;
    logic [1:0] bitCnt;
    logic [3:0] latchCnt;
    logic latchArm;
    logic [3:0] buf1;
    logic buf1Full;
    logic [3:0] buf2;
    logic [1:0] outIdx;
    logic outValid;
    logic dout;
    logic doutOk;
    logic [3:0] wShift;
    logic [3:0] wdata;
    logic ovf;
    logic [31:0] rdata;
  } cbtc_regs_t;

  cbtc_regs_t r;
  cbtc_regs_t next_r;

  logic bitTick;
  logic ccdTick;
  logic vaTick;
  logic [31:0] flagEff;
  logic [31:0] selLine;
  logic [32:0] chain;
  logic selOvf;
  logic [4:0] selIdx;
  logic apbWr;
  logic apbSetup;
  logic addrOk;
  logic writeReq;
  logic readCmd;
  logic [31:0] statWord;

  // ----------------------------------------------------------------
  // selector array
  // ----------------------------------------------------------------
  // flag seen by each cell depends on direction and read mode
  assign flagEff = !r.isRead ? r.valid : // [RQ2]
    r.destr ? ~r.valid : // [RQ5]
    ~r.valid | r.aux; // [RQ6]

  assign chain[0] = 1'b1;
  for (genvar i = 0; i < 32; i++) begin : g_cell
    cbtc_sel_cell u_cell (
      .enIn(chain[i]),
      .enOut(chain[i+1]),
      .chosen(r.chosen[i]),
      .flag(flagEff[i]),
      .selected(selLine[i])
    );
  end
  // nothing left to select at the top of the chain
  assign selOvf = chain[32]; // [RQ7]

  // one-hot to binary; only one line is ever high
  function automatic logic [4:0] onehot_idx(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int k = 0; k < 32; k++) begin
      if (v[k]) begin
        idx = k[4:0];
      end
    end
    return idx;
  endfunction
  assign selIdx = onehot_idx(selLine); // [RQ8]

  // ----------------------------------------------------------------
  // timing: bit rate, transfer cycle, virtual address
  // ----------------------------------------------------------------
  assign bitTick = (r.divCnt == 8'(BIT_DIV - 1));
  assign ccdTick = bitTick && (r.bitCnt == 2'h3);
  assign vaTick = ccdTick && (r.vaddr == 8'h00);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pwrite && addrOk;
  assign readCmd = apbWr && paddr == `CBTC_OFF_CMD && pwdata[`CBTC_CMD_READ];
  always_comb begin
    case (paddr)
      `CBTC_OFF_CTRL, `CBTC_OFF_CMD, `CBTC_OFF_CHOSEN,
      `CBTC_OFF_FLAGS, `CBTC_OFF_STAT: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end
  // writes to read-only words are refused like unmapped ones
  assign pready = psel && penable;
  assign pslverr = psel && penable && (!addrOk || (pwrite &&
    (paddr == `CBTC_OFF_FLAGS || paddr == `CBTC_OFF_STAT)));

  always_comb begin
    statWord = 32'h00000000;
    statWord[`CBTC_ST_BUSY] = busy;
    statWord[`CBTC_ST_DAC] = dac;
    statWord[`CBTC_ST_XFER] = xferReq;
    statWord[`CBTC_ST_OVF] = r.ovf;
    statWord[`CBTC_ST_RDPEND] = r.readPend;
    statWord[`CBTC_ST_TRACK +: 5] = memTrack;
    statWord[`CBTC_ST_CE +: 4] = r.ce;
  end

  // data input available is the write request
  assign writeReq = !dataInAvailN;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    // dividers and virtual address run free, so data stays refreshed
    next_r.divCnt = bitTick ? 8'h00 : r.divCnt + 8'h01;
    next_r.bitCnt = r.bitCnt + 2'(bitTick);
    next_r.vaddr = r.vaddr + 8'(ccdTick);

    // register reads sampled in the setup phase
    if (apbSetup) begin
      case (paddr)
        `CBTC_OFF_CTRL: next_r.rdata = {31'h0, r.destr};
        `CBTC_OFF_CHOSEN: next_r.rdata = r.chosen;
        `CBTC_OFF_FLAGS: next_r.rdata = r.valid;
        `CBTC_OFF_STAT: next_r.rdata = statWord;
        default: next_r.rdata = 32'h00000000;
      endcase
    end
    // manual clear first, so a same-cycle write start still sets
    if (apbWr && paddr == `CBTC_OFF_CMD && pwdata[`CBTC_CMD_CLEAR]) begin
      next_r.valid = r.valid & ~r.chosen; // [RQ1]
    end
    if (readCmd) begin
      next_r.readPend = 1'b1; // [RQ17]
    end
    // mode and chosen set may only change while nothing is in flight
    if (apbWr && paddr == `CBTC_OFF_CTRL && r.state == CBTC_IDLE) begin
      next_r.destr = pwdata[`CBTC_CTRL_DESTR];
    end
    if (apbWr && paddr == `CBTC_OFF_CHOSEN && r.state == CBTC_IDLE) begin
      next_r.chosen = pwdata;
    end

    // write data: gather four serial bits per transfer cycle
    if (bitTick && r.state == CBTC_XFER && !r.isRead) begin
      next_r.wShift = {dataIn, r.wShift[3:1]};
    end
    if (ccdTick && r.state == CBTC_XFER && !r.isRead) begin
      next_r.wdata = {dataIn, r.wShift[3:1]};
    end

    // read capture a fixed delay after the third phase rise
    if (ccdTick && r.state == CBTC_XFER && r.isRead) begin
      next_r.latchArm = 1'b1;
      next_r.latchCnt = 4'h0;
    end else if (r.latchArm) begin
      if (r.latchCnt == 4'(LATCH_CYC - 1)) begin
        next_r.latchArm = 1'b0;
        next_r.buf1 = memRdata; // [RQ12]
        next_r.buf1Full = 1'b1;
      end else begin
        next_r.latchCnt = r.latchCnt + 4'h1;
      end
    end
    // second register loads at the next cycle start; serial out follows
    if (ccdTick) begin
      next_r.outValid = r.buf1Full; // [RQ15]
      next_r.buf1Full = 1'b0;
      next_r.buf2 = r.buf1; // [RQ13]
      next_r.outIdx = 2'h0;
    end
    // available flag follows dout, one bit tick behind outValid
    next_r.doutOk = bitTick ? r.outValid : r.doutOk; // [RQ15]
    if (bitTick && r.outValid) begin
      next_r.dout = r.buf2[r.outIdx]; // [RQ14]
      next_r.outIdx = r.outIdx + 2'h1;
    end

    // sequencer
    case (r.state)
      CBTC_IDLE: begin
        next_r.ovf = 1'b0;
        next_r.track = 2'h0;
        if (writeReq) begin
          next_r.isRead = 1'b0; // [RQ18]
          next_r.state = CBTC_SETUP;
        end else if (r.readPend) begin
          next_r.isRead = 1'b1; // [RQ18]
          next_r.state = CBTC_SETUP;
        end
      end
      CBTC_SETUP: begin
        next_r.ovf = selOvf; // [RQ22]
        if (selOvf) begin
          // read finished or memory full: back to write-ready idle
          next_r.state = CBTC_IDLE; // [RQ7]
          if (r.isRead) begin
            next_r.readPend = readCmd; // [RQ17] a fresh request wins
            next_r.aux = 32'h00000000; // [RQ6]
          end
          next_r.isRead = 1'b0;
        end else if (vaTick) begin
          next_r.state = CBTC_XFER;
          next_r.blkAddr = selIdx[2:0]; // [RQ10]
          next_r.ce = 4'h1 << selIdx[4:3]; // [RQ8] [RQ10]
          next_r.track = 2'h0; // [RQ24]
          if (!r.isRead) begin
            next_r.valid = next_r.valid | selLine; // [RQ4] [RQ1]
          end else if (r.destr) begin
            next_r.valid = next_r.valid & ~selLine; // [RQ5]
          end else begin
            next_r.aux = r.aux | selLine; // [RQ6]
          end
        end
      end
      CBTC_XFER: begin
        if (vaTick) begin
          if (r.track == 2'h2) begin
            // block complete after its fourth track
            next_r.track = 2'h0; // [RQ24]
            if (r.isRead || writeReq) begin
              next_r.state = CBTC_SETUP; // [RQ17] [RQ20]
            end else begin
              next_r.state = CBTC_IDLE;
            end
          end else begin
            // gray order keeps one bit changing per step
            next_r.track = {r.track[0], ~r.track[1]}; // [RQ11] [RQ24]
          end
        end
      end
      default: begin
        next_r.state = CBTC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '0;
      r.chosen <= `CBTC_RST_CHOSEN;
      r.destr <= `CBTC_RST_DESTR;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = r.rdata;
  // enables only during a block transfer; idle inhibits the board
  assign memCe = (r.state == CBTC_XFER) ? r.ce : 4'h0; // [RQ16]
  assign memWrite = !r.isRead; // [RQ16]
  assign memTrack = {r.blkAddr, r.track}; // [RQ9] [RQ11]
  assign memWdata = r.wdata;
  assign phase3Tick = ccdTick;
  assign virtualAddressZero = (r.vaddr == 8'h00);
  assign busy = (r.state != CBTC_IDLE); // [RQ19]
  assign dac = (r.state != CBTC_IDLE); // [RQ20]
  assign xferReq = (r.state == CBTC_XFER); // [RQ21]
  assign memOverflow = r.ovf; // [RQ22]
  assign dataOut = r.dout;
  // read gating hides a stale tail once a write has taken over
  assign dataOutAvailN = !(r.doutOk && r.isRead); // [RQ15]

endmodule

/* File: cbtc_top_tb.sv */
// self-checking bench for the block transfer control
`timescale 1ns/1ps
`include "cbtc_map.svh"
module cbtc_top_tb;
  // ----------
  // signals and design
  // ----------
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic reqOn = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, dataIn, dataInAvailN, dataOut, dataOutAvailN;
  logic [3:0] memRdata, memWdata, memCe, firstNib, ceSeen;
  logic [4:0] memTrack;
  logic [2:0] blkSeen;
  logic memWrite, phase3Tick, virtualAddressZero, busy, dac, xferReq;
  logic memOverflow;
  logic [3:0] wdSeen;
  int ovfCnt = 0;
  int availCnt = 0;
  int mismatches = 0;
  int testsRun = 0;

  always #20 mclk = ~mclk;

  // short bit divider keeps a 4096-bit block near 8k cycles
  cbtc_top #(.BIT_DIV(2)) i_dut (
    .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dataIn, .dataInAvailN, .dataOut, .dataOutAvailN,
    .memRdata, .memWdata, .memTrack, .memCe, .memWrite, .phase3Tick,
    .virtualAddressZero, .busy, .dac, .xferReq, .memOverflow);
  cbtc_far_model #(.DIV(2)) i_far (.mclk, .nrst, .reqOn, .firstNib,
    .dataIn, .dataInAvailN, .dataOut, .dataOutAvailN, .memCe, .memRdata);

  // remember what the memory side showed during the last transfer
  always @(posedge mclk) begin
    if (xferReq === 1'b1) begin
      ceSeen <= memCe;
      blkSeen <= memTrack[4:2];
    end
    if (xferReq === 1'b1 && memWrite === 1'b1) wdSeen <= memWdata;
    if (memOverflow === 1'b1) ovfCnt <= ovfCnt + 1;
    if (dataOutAvailN === 1'b0) availCnt <= availCnt + 1;
  end

  // ----------
  // shared tasks
  // ----------
  task automatic closeOut();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n == 20) begin
      cmp("pready", 32'h1, 32'h0);
      closeOut();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(what, exp, q);
  endtask

  task automatic waitBusy(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && busy !== lvl; n++) @(posedge mclk);
    if (n == lim) begin
      cmp("busy", 32'(lvl), 32'(busy));
      closeOut();
    end
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic scRegs();
    logic [31:0] q;
    logic e;
    rdchk("control", `CBTC_OFF_CTRL, 32'h0);
    rdchk("chosen", `CBTC_OFF_CHOSEN, `CBTC_RST_CHOSEN);
    rdchk("status", `CBTC_OFF_STAT, 32'h0);
    apb(1'b1, `CBTC_OFF_FLAGS, 32'hff, q, e);
    cmp("flags write error", 32'h1, 32'(e));
    rdchk("flags", `CBTC_OFF_FLAGS, 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, e);
    cmp("unmapped error", 32'h1, 32'(e));
  endtask

  // burst far shorter than a block: the block must still complete
  task automatic scWrite(input logic [31:0] ch, input logic [3:0] ce,
      input logic [2:0] blk, input logic [31:0] fl);
    wr(`CBTC_OFF_CHOSEN, ch);
    reqOn <= 1'b1;
    waitBusy(1'b1, 100);
    repeat (64) @(posedge mclk);
    reqOn <= 1'b0;
    waitBusy(1'b0, 30000);
    cmp("bank enable", 32'(ce), 32'(ceSeen));
    cmp("block address", 32'(blk), 32'(blkSeen));
    cmp("write nibble", 32'h1,
      32'(wdSeen == 4'h5 || wdSeen == 4'ha));
    rdchk("flags", `CBTC_OFF_FLAGS, fl);
  endtask

  task automatic scOverflow();
    int n;
    int o0;
    o0 = ovfCnt;
    wr(`CBTC_OFF_CHOSEN, 32'h1);
    reqOn <= 1'b1;
    for (n = 0; n < 3000 && ovfCnt == o0; n++) @(posedge mclk);
    reqOn <= 1'b0;
    waitBusy(1'b0, 3000);
    cmp("overflow", 32'h1, 32'(ovfCnt != o0));
    if (n == 3000) closeOut();
    rdchk("flags", `CBTC_OFF_FLAGS, 32'h201);
  endtask

  task automatic scNdRead();
    int a0;
    a0 = availCnt;
    wr(`CBTC_OFF_CTRL, 32'h0);
    wr(`CBTC_OFF_CHOSEN, 32'h1);
    wr(`CBTC_OFF_CMD, 32'h1);
    waitBusy(1'b1, 100);
    waitBusy(1'b0, 30000);
    rdchk("flags", `CBTC_OFF_FLAGS, 32'h201);
    cmp("output available", 32'h1, 32'(availCnt != a0));
    cmp("first nibble", 32'h1, 32'(firstNib));
  endtask

  // a write asked for mid-read must wait; then both blocks are free
  task automatic scDrRead();
    int n;
    logic bad;
    bad = 1'b0;
    wr(`CBTC_OFF_CTRL, 32'h1);
    wr(`CBTC_OFF_CHOSEN, 32'h201);
    wr(`CBTC_OFF_CMD, 32'h1);
    waitBusy(1'b1, 100);
    reqOn <= 1'b1;
    for (n = 0; n < 30000 && busy === 1'b1; n++) begin
      @(posedge mclk);
      if (busy === 1'b1 && memWrite !== 1'b0) bad = 1'b1;
    end
    cmp("held off write", 32'h0, 32'(bad || n == 30000));
    if (n == 30000) closeOut();
    waitBusy(1'b1, 100);
    repeat (64) @(posedge mclk);
    reqOn <= 1'b0;
    waitBusy(1'b0, 30000);
    rdchk("flags", `CBTC_OFF_FLAGS, 32'h1);
    wr(`CBTC_OFF_CMD, 32'h2);
    rdchk("flags", `CBTC_OFF_FLAGS, 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    scRegs();
    scWrite(32'h3, 4'h1, 3'h0, 32'h1);
    scWrite(32'h201, 4'h2, 3'h1, 32'h201);
    scOverflow();
    scNdRead();
    scDrRead();
    closeOut();
  end
endmodule
